// ===== design/dmarc_top.sv
/*
  DMA buffer RAM with core and DMA ports, channel address and count registers,
  and the channel 5 completion flag, reached over classic Wishbone.
  Assumes the core drives the core RAM port in lockstep with the core clock and
  that the DMA controller raises a one-cycle transfer strobe per channel.
*/
// The implementer's own choices: the address map and the Wishbone slave port.
`default_nettype none
// Functional notes
// - 2 Kbyte dual-ported buffer at Y top
// - Core and DMA access same cycle
// - DMA never stalls the core
// - Core write wins same-address clash
// - Buffer is DMA source and destination
// - 16-bit address register, resets zero
// - 10-bit count, upper bits read zero
// - Transfers equal count plus one
// - Channel 5 done sets sticky flag
module dmarc_top
  import dmarc_pkg::*;
(
  // Clock and reset.
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RST_B_IN,
  // Wishbone slave.
  input  wire logic                 WB_CYC_IN,
  input  wire logic                 WB_STB_IN,
  input  wire logic                 WB_WE_IN,
  input  wire logic [7:0]           WB_ADR_IN,
  input  wire logic [3:0]           WB_SEL_IN,
  input  wire logic [31:0]          WB_DAT_IN,
  output logic [31:0]               WB_DAT_OUT,
  output logic                      WB_ACK_OUT,
  // Core RAM port.
  input  wire dmarc_ram_req_t       CORE_REQ_IN,
  output logic [DW-1:0]             CORE_RDATA_OUT,
  // DMA RAM port.
  input  wire dmarc_ram_req_t       DMA_REQ_IN,
  output logic [DW-1:0]             DMA_RDATA_OUT,
  output logic                      DMA_LOST_OUT,
  // DMA controller channel strobes.
  input  wire logic [NUM_CH-1:0]    CH_XFER_IN,
  output logic [NUM_CH-1:0]         CH_BUSY_OUT
);
  logic                    wb_req;
  logic                    ack_r;
  logic [31:0]             dat_r;
  logic [NUM_CH-1:0]       chen_r;
  logic                    done5_r;
  logic [NUM_CH-1:0]       pad_we;
  logic [NUM_CH-1:0]       cnt_we;
  logic [NUM_CH-1:0]       start;
  logic [NUM_CH-1:0]       done;
  logic [NUM_CH-1:0]       busy;
  logic [DW-1:0]           pad    [NUM_CH];
  logic [CNT_W-1:0]        cnt    [NUM_CH];
  logic                    wr_lo;
  logic [31:0]             rd_nxt;
  logic [15:0]             irq_flag_reg3_rd;

  // A new request is one that has not been acknowledged yet.
  assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_r;
  // The registers are 16 bits wide, so only the low two byte lanes matter.
  assign wr_lo  = wb_req && WB_WE_IN && (WB_SEL_IN[1:0] == 2'b11);

  // Per-channel write strobes and a start request while enabled and idle.
  // The done cycle is excluded: busy has already fallen but the enable bit
  // only clears on the next edge, so a finished channel would restart.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      pad_we[i] = wr_lo && (WB_ADR_IN == OFS_PAD_BASE + 8'(4 * i));
      cnt_we[i] = wr_lo && (WB_ADR_IN == OFS_CNT_BASE + 8'(4 * i));
      start[i]  = chen_r[i] && !busy[i] && !done[i];
    end
  end

  // Channel instances; software keeps registers stable while a channel is enabled.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    dmarc_channel u_ch (
      .clk    (CORE_CLK_IN),
      .rst_b  (RST_B_IN),
      .pad_we (pad_we[g]),
      .cnt_we (cnt_we[g]),
      .wdata  (WB_DAT_IN[DW-1:0]),
      .start  (start[g]),
      .xfer   (CH_XFER_IN[g]),
      .pad_r  (pad[g]),
      .cnt_r  (cnt[g]),
      .busy_r (busy[g]),
      .done   (done[g])
    );
  end

  // The buffer RAM: core and DMA ports are independent, so the core never waits.
  dmarc_dpram u_ram (
    .clk        (CORE_CLK_IN),
    .core_req   (CORE_REQ_IN),
    .core_rdata (CORE_RDATA_OUT),
    .dma_req    (DMA_REQ_IN),
    .dma_rdata  (DMA_RDATA_OUT),
    .dma_lost   (DMA_LOST_OUT)
  );

  // Channel enables; an enable bit clears itself when its channel finishes.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      chen_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (done[i]) begin
          chen_r[i] <= 1'b0;
        end else if (wr_lo && WB_ADR_IN == OFS_CHEN) begin
          chen_r[i] <= WB_DAT_IN[i];
        end
      end
    end
  end

  // Channel 5 completion flag: hardware set wins over a software clear.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      done5_r <= 1'b0;
    end else if (done[DONE_CH]) begin
      done5_r <= 1'b1;
    end else if (wr_lo && WB_ADR_IN == OFS_IRQ_FLAG_REG3) begin
      done5_r <= WB_DAT_IN[DONE_BIT];
    end
  end

  assign irq_flag_reg3_rd = 16'(done5_r) << DONE_BIT;

  // Read multiplexer; unmapped addresses read as zero and are still acknowledged.
  always_comb begin
    rd_nxt = UNMAPPED_RD;
    for (int i = 0; i < NUM_CH; i++) begin
      if (WB_ADR_IN == OFS_PAD_BASE + 8'(4 * i)) begin
        rd_nxt = {16'h0000, pad[i]};
      end
      if (WB_ADR_IN == OFS_CNT_BASE + 8'(4 * i)) begin
        rd_nxt = {22'h00_0000, cnt[i]};
      end
    end
    if (WB_ADR_IN == OFS_IRQ_FLAG_REG3) begin
      rd_nxt = {16'h0000, irq_flag_reg3_rd};
    end
    if (WB_ADR_IN == OFS_CHEN) begin
      rd_nxt = {24'h00_0000, chen_r};
    end
    if (WB_ADR_IN == OFS_STATUS) begin
      rd_nxt = {24'h00_0000, busy};
    end
  end

  // One-cycle registered acknowledge, dropped in the following cycle.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !WB_WE_IN) begin
        dat_r <= rd_nxt;
      end
    end
  end

  assign WB_ACK_OUT  = ack_r;
  assign WB_DAT_OUT  = dat_r;
  assign CH_BUSY_OUT = busy;

  // Helper counter of transfers taken by channel 0 while busy.
  logic [CNT_W:0] seen_r;
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN || start[0]) begin
      seen_r <= '0;
    end else if (busy[0] && CH_XFER_IN[0]) begin
      seen_r <= seen_r + 1'b1;
    end
  end

  property p_count_plus_one;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    done[0] |-> seen_r == {1'b0, cnt[0]} + 1'b1;
  endproperty
  a_count_plus_one: assert property (p_count_plus_one)
    else $error("Channel 0 transfer count differs from count plus one.");

  property p_core_wins;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (CORE_REQ_IN.en && CORE_REQ_IN.we && DMA_REQ_IN.en && DMA_REQ_IN.we &&
     CORE_REQ_IN.addr == DMA_REQ_IN.addr) |=> DMA_LOST_OUT;
  endproperty
  a_core_wins: assert property (p_core_wins)
    else $error("Same-address write clash not resolved for the core.");

  property p_no_false_clash;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    !(CORE_REQ_IN.en && CORE_REQ_IN.we) |=> !DMA_LOST_OUT;
  endproperty
  a_no_false_clash: assert property (p_no_false_clash)
    else $error("DMA write dropped without a core write.");

  property p_done_flag;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    done[DONE_CH] |=> done5_r;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("Channel 5 completion did not set its flag.");

  property p_flag_sticky;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    done5_r && !(wr_lo && WB_ADR_IN == OFS_IRQ_FLAG_REG3) |=> done5_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Completion flag dropped without a software clear.");

  property p_cnt_upper_zero;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (wb_req && !WB_WE_IN && WB_ADR_IN == OFS_CNT_BASE) |=> WB_DAT_OUT[31:CNT_W] == '0;
  endproperty
  a_cnt_upper_zero: assert property (p_cnt_upper_zero)
    else $error("Count register upper bits not zero.");

  property p_pad_write;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    pad_we[0] |=> pad[0] == $past(WB_DAT_IN[15:0]);
  endproperty
  a_pad_write: assert property (p_pad_write)
    else $error("Peripheral address register did not take the write.");

  property p_ack_one;
    @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    wb_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("Acknowledge not a single cycle after request.");

  c_clash:  cover property (@(posedge CORE_CLK_IN) DMA_LOST_OUT);
  c_done5:  cover property (@(posedge CORE_CLK_IN) done[DONE_CH]);
  c_single: cover property (@(posedge CORE_CLK_IN) done[0] && cnt[0] == '0);
endmodule : dmarc_top
`default_nettype wire

// ===== inc/dmarc_pkg.sv
/*
  Shared constants and carrier types for the DMA buffer RAM and channel register block.
  Assumes one core clock and a synchronous active-low reset.
*/
`default_nettype none
package dmarc_pkg;
  // Buffer geometry: 2 Kbytes held as 1024 words of 16 bits.
  localparam int unsigned RAM_BYTES    = 2048;
  localparam int unsigned RAM_WORDS    = RAM_BYTES / 2;
  localparam int unsigned RAM_AW       = 10;
  localparam int unsigned DW           = 16;
  localparam int unsigned NUM_CH       = 8;
  localparam int unsigned DONE_CH      = 5;
  // Byte base of the buffer at the top of the 64 Kbyte data space.
  localparam logic [15:0] RAM_BASE     = 16'hF800;
  // Register map on the Wishbone port (word index = byte address bits 7:2).
  localparam logic [7:0]  OFS_PAD_BASE = 8'h00;
  localparam logic [7:0]  OFS_CNT_BASE = 8'h20;
  localparam logic [7:0]  OFS_IRQ_FLAG_REG3     = 8'h40;
  localparam logic [7:0]  OFS_CHEN     = 8'h44;
  localparam logic [7:0]  OFS_STATUS   = 8'h48;
  localparam int unsigned CNT_W        = 10;
  localparam int unsigned DONE_BIT     = 13;
  localparam logic [15:0] PAD_RST      = 16'h0000;
  localparam logic [9:0]  CNT_RST      = 10'h000;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // One access to the buffer RAM.
  typedef struct packed {
    logic              en;
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [DW-1:0]     wdata;
  } dmarc_ram_req_t;
endpackage : dmarc_pkg
`default_nettype wire

// ===== design/dmarc_dpram.sv
/*
  Dual-ported buffer RAM with one core port and one DMA port.
  Assumes both ports share the single core clock.
*/
`default_nettype none
module dmarc_dpram
  import dmarc_pkg::*;
(
  // Clock.
  input  wire logic           clk,
  // Core port.
  input  wire dmarc_ram_req_t core_req,
  output logic [DW-1:0]       core_rdata,
  // DMA port.
  input  wire dmarc_ram_req_t dma_req,
  output logic [DW-1:0]       dma_rdata,
  output logic                dma_lost
);
  logic [DW-1:0] mem [RAM_WORDS];
  logic          clash;

  // A same-address write clash is resolved for the core; the DMA write is dropped.
  assign clash = core_req.en && core_req.we && dma_req.en && dma_req.we &&
                 (core_req.addr == dma_req.addr);

  // Both ports act in the same cycle; the write of the core is applied last.
  always_ff @(posedge clk) begin
    if (dma_req.en && dma_req.we && !clash) begin
      mem[dma_req.addr] <= dma_req.wdata;
    end
    if (core_req.en && core_req.we) begin
      mem[core_req.addr] <= core_req.wdata;
    end
  end

  // Reads return the old contents one cycle later on each port independently.
  always_ff @(posedge clk) begin
    if (core_req.en) begin
      core_rdata <= mem[core_req.addr];
    end
    if (dma_req.en) begin
      dma_rdata <= mem[dma_req.addr];
    end
    dma_lost <= clash;
  end
endmodule : dmarc_dpram
`default_nettype wire

// ===== design/dmarc_channel.sv
/*
  One DMA channel: address and count registers and a transfer counter.
  Assumes register writes arrive while the channel is disabled.
*/
`default_nettype none
module dmarc_channel
  import dmarc_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Register writes.
  input  wire logic             pad_we,
  input  wire logic             cnt_we,
  input  wire logic [DW-1:0]    wdata,
  // Transfer control.
  input  wire logic             start,
  input  wire logic             xfer,
  // State.
  output logic [DW-1:0]         pad_r,
  output logic [CNT_W-1:0]      cnt_r,
  output logic                  busy_r,
  output logic                  done
);
  logic [CNT_W-1:0] left_r;

  // Peripheral address register, cleared at reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pad_r <= PAD_RST;
    end else if (pad_we) begin
      pad_r <= wdata;
    end
  end

  // Count field, ten bits wide.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= CNT_RST;
    end else if (cnt_we) begin
      cnt_r <= wdata[CNT_W-1:0];
    end
  end

  // Remaining transfers minus one; the last transfer happens at zero, giving count plus one.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      left_r <= '0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        left_r <= cnt_r;
      end else if (busy_r && xfer) begin
        if (left_r == '0) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end else begin
          left_r <= left_r - 1'b1;
        end
      end
    end
  end
endmodule : dmarc_channel
`default_nettype wire

// ===== tb/dmarc_dma_model.sv
/*
  DMA controller stand-in that strobes every running channel.
  Assumes the block's busy outputs are registered on the core clock.
*/
`default_nettype none
module dmarc_dma_model
  import dmarc_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Channel state and pace.
  input  wire logic [NUM_CH-1:0] busy,
  input  wire logic              slow,
  // Strobes and tally.
  output logic [NUM_CH-1:0]      xfer,
  output logic [31:0]            n_xfer
);
  logic [1:0] pace_r;
  // Strobe each cycle, or every fourth when slow, so the block must wait.
  always_ff @(posedge clk) begin
    pace_r <= rst_b ? pace_r + 2'd1 : 2'd0;
    xfer   <= (rst_b && (!slow || pace_r == 2'd3)) ? busy : '0;
  end
  // Only strobes that land on a running channel count as transfers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      n_xfer <= '0;
    end else begin
      n_xfer <= n_xfer + 32'($countones(xfer & busy));
    end
  end
endmodule // dmarc_dma_model
`default_nettype wire

// ===== tb/dmarc_top_tb.sv
/*
  Self-checking bench for the DMA buffer RAM and channel register block.
  Assumes the register map, latencies and reset values of the package.
*/
`default_nettype none
module dmarc_top_tb
  import dmarc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic w; logic [3:0] s; logic [7:0] a; logic [15:0] d; logic [15:0] e;
  } dmarc_row_t;
  logic              clk, rst_b, cyc, stb, we, slow, ack, lost;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       wdat, rdat, q, nx;
  logic [15:0]       crd, drd;
  logic [NUM_CH-1:0] xf, busy;
  dmarc_ram_req_t    creq, dreq;
  int                failures = 0;
  int                n_compared = 0;
  // Reset values, write-read pairs, a lane-refused write and an unmapped place.
  dmarc_row_t rows [8] = '{
    '{0, 4'hF, 8'h00, 16'h0000, 16'h0000}, '{0, 4'hF, 8'h3C, 16'h0000, 16'h0000},
    '{0, 4'hF, 8'h40, 16'h0000, 16'h0000}, '{1, 4'hF, 8'h00, 16'hA55A, 16'hA55A},
    '{1, 4'hF, 8'h1C, 16'hFFFF, 16'hFFFF}, '{1, 4'hF, 8'h20, 16'hFFFF, 16'h03FF},
    '{1, 4'h1, 8'h00, 16'h1234, 16'hA55A}, '{1, 4'hF, 8'h80, 16'hFFFF, 16'h0000}};

  dmarc_top dmarc_top_i (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CORE_REQ_IN(creq), .CORE_RDATA_OUT(crd),
    .DMA_REQ_IN(dreq), .DMA_RDATA_OUT(drd), .DMA_LOST_OUT(lost), .CH_XFER_IN(xf),
    .CH_BUSY_OUT(busy));
  dmarc_dma_model dmarc_dma_model_i (.clk(clk), .rst_b(rst_b), .busy(busy),
    .slow(slow), .xfer(xf), .n_xfer(nx));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, s, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    if (n >= 20) failures++;
    {cyc, stb, we} <= 3'b000;
  endtask
  function automatic dmarc_ram_req_t mk(input logic w, input logic [9:0] a,
                                        input logic [15:0] d);
    return '{1'b1, w, a, d};
  endfunction
  // Both RAM ports are offered in the same cycle.
  task automatic ram(input dmarc_ram_req_t c, input dmarc_ram_req_t d);
    @(posedge clk);
    creq <= c;
    dreq <= d;
    @(posedge clk);
    creq <= '0;
    dreq <= '0;
    #1;
  endtask
  // Program a count while idle, enable, then tally strobes until it stops.
  task automatic chan(input int c, input logic [9:0] n, input logic s);
    logic [31:0] b;
    int k;
    wb(1, 4'hF, 8'h20 + 8'(4 * c), {22'h0, n}, q);
    slow <= s;
    b = nx;
    wb(1, 4'hF, OFS_CHEN, 32'(1) << c, q);
    k = 0;
    while (busy[c] !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    while (busy[c] !== 1'b0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (2) @(posedge clk);
    chk("transfers", 32'(n) + 1, nx - b);
    wb(0, 4'hF, OFS_CHEN, 0, q);
    chk("enable", 0, q);
  endtask
  task automatic end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Clock generator.
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Watchdog sized well past the hundred or so cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {rst_b, cyc, stb, we, slow, adr, sel, wdat} = '0;
    creq = '0;
    dreq = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wb(1, rows[i].s, rows[i].a, {16'h0, rows[i].d}, q);
      wb(0, 4'hF, rows[i].a, 0, q);
      chk("register", {16'h0, rows[i].e}, q);
    end
    ram(mk(1, 10'h005, 16'h1111), mk(1, 10'h005, 16'h2222));
    chk("lost", 1, {31'h0, lost});
    ram(mk(0, 10'h005, 0), mk(0, 10'h005, 0));
    chk("core rd", 16'h1111, {16'h0, crd});
    chk("dma rd", 16'h1111, {16'h0, drd});
    ram(mk(1, 10'h3FF, 16'hBEEF), mk(1, 10'h000, 16'hCAFE));
    chk("no loss", 0, {31'h0, lost});
    ram(mk(0, 10'h000, 0), mk(0, 10'h3FF, 0));
    chk("core sees dma", 16'hCAFE, {16'h0, crd});
    chk("dma sees top", 16'hBEEF, {16'h0, drd});
    chan(0, 10'h000, 1'b0);
    wb(0, 4'hF, OFS_IRQ_FLAG_REG3, 0, q);
    chk("flag idle", 0, q);
    chan(5, 10'h002, 1'b1);
    wb(0, 4'hF, OFS_IRQ_FLAG_REG3, 0, q);
    chk("flag set", 32'h0000_2000, q);
    wb(1, 4'hF, OFS_IRQ_FLAG_REG3, 0, q);
    wb(0, 4'hF, OFS_IRQ_FLAG_REG3, 0, q);
    chk("flag clear", 0, q);
    // A reset in mid-run must clear the address register written above.
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, 4'hF, OFS_PAD_BASE, 0, q);
    chk("pad after reset", 0, q);
    end_of_test();
  end
endmodule // dmarc_top_tb
`default_nettype wire
